// >>> logic/gcm_handler.sv
// command/indicate and supervision channel handler for two multiplexes of 8 channels.
// assumes slot bytes arrive from serialisers on CLOCK_I, and that the event consumer
// writes each event word into shared memory.
// What this block does
// RULE1 - serve 16 primitive and 16 supervision channels from multiplexes four and five
// RULE2 - each multiplex has 8 channels of 4 slots: B1, B2, supervision, signalling
// RULE3 - supervision and signalling slots stay put for both protocol styles
// RULE4 - the two data bytes pass through untouched
// RULE5 - ISDN signalling bytes carry two D bits beside the primitive field
// RULE6 - primitive field per channel: off, 6-bit analog or 4-bit ISDN
// RULE7 - supervision per channel: off, V-star or GCI, mixed across channels
// RULE8 - GCI: sender raises E per new byte, receiver answers with A
// RULE9 - V-star: no handshake, E marks valid byte, unused bit held at 1
// RULE10 - supervision byte in one slot, primitive and handshake in the next
// RULE11 - received D bits go to matrix output 7 and the HDLC receiver
// RULE12 - transmit signalling and supervision bytes rebuilt from three contributors
// RULE13 - received primitives and messages are queued to shared memory
// RULE14 - 16 primitive and 16 supervision transmit command registers, read/write
// RULE15 - B channel shuffling into 32 of 256 slots is selectable
// RULE16 - ISDN side channel is two data slots plus D, A, E and spare bits
// RULE17 - host gives 32 distinct slots when upstream shuffling is on
// RULE18 - host keeps all 32 shuffled channels on subscriber channels
// RULE19 - six-bit word sent upstream under a configuration bit
// RULE20 - received six-bit words are stored to shared memory
// RULE21 - alarm indication on 16-bit data pairs detected and recorded when enabled
`timescale 1ns/10ps
module gcm_handler (
  // clock, reset, enable
  input  wire logic              CLOCK_I,
  input  wire logic              RESET_N_I,
  input  wire logic              CE_I,
  // register port
  input  wire logic [7:0]        REG_ADDR_I,
  input  wire logic [15:0]       REG_WDATA_I,
  input  wire logic              REG_WR_I,
  input  wire logic              REG_RD_I,
  output logic      [15:0]       REG_RDATA_O,
  output logic                   REG_RACK_O,
  // receive slot stream
  input  wire logic              RX_VALID_I,
  input  wire gcm_pkg::gcm_slot_t RX_SLOT_I,
  output logic                   RX_READY_O,
  // receive data and D towards the matrix and HDLC receiver
  output logic      [7:0]        RX_B_O,
  output logic                   RX_B_VALID_O,
  output logic      [1:0]        RX_D_O,
  output logic      [3:0]        RX_D_CHAN_O,
  output logic                   RX_D_VALID_O,
  // transmit slot requests and answers
  input  wire logic              TX_REQ_I,
  input  wire gcm_pkg::gcm_slot_t TX_SLOT_I,
  output logic      [7:0]        TX_BYTE_O,
  output logic                   TX_VALID_O,
  // event queue towards shared memory
  output logic                   EVT_VALID_O,
  output gcm_pkg::gcm_evt_t      EVT_O,
  input  wire logic              EVT_READY_I,
  // matrix control
  output logic                   SHUFFLE_EN_O
);
  import gcm_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [CHAN_W-1:0] chan_of(input logic mux, input logic [SLOT_W-1:0] slot);
    chan_of = {mux, slot[SLOT_W-1:2]};  // four slots per channel
  endfunction

  function automatic logic [MEM_AW-1:0] mem_index(input logic is_mon, input logic [CHAN_W-1:0] ch);
    mem_index = {is_mon, ch};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] gencfg, matcfg, cmem, next_gencfg, next_matcfg, next_cmem;
  logic [1:0]  ci_mode [NUM_CHAN];
  logic [1:0]  mon_mode [NUM_CHAN];
  logic [1:0]  next_ci_mode [NUM_CHAN];
  logic [1:0]  next_mon_mode [NUM_CHAN];
  logic [5:0]  last_ci [NUM_CHAN];
  logic [5:0]  next_last_ci [NUM_CHAN];
  logic [5:0]  six_last [NUM_CHAN];
  logic [5:0]  next_six_last [NUM_CHAN];
  logic [7:0]  mon_rx [NUM_CHAN];
  logic [7:0]  next_mon_rx [NUM_CHAN];
  logic [NUM_CHAN-1:0] rx_e_last, next_rx_e_last, b1_ones, next_b1_ones;
  logic [NUM_CHAN-1:0] ais_state, next_ais_state, pend, next_pend;
  logic        rd_p1, rd_mem_q, next_rd_p1, next_rd_mem_q;
  logic [15:0] rd_hold, next_rd_hold, next_rdata;
  logic        six_en, ais_en, rx_take, mon_wr, mem_we;
  logic [MEM_AW-1:0] mem_a_addr, mem_b_addr;
  logic [MEM_DW-1:0] mem_a_rdata, mem_b_rdata;
  logic [CHAN_W-1:0] reg_ch;

  assign six_en  = gencfg[GCR_SIX_BIT];
  assign ais_en  = matcfg[MATRIX_CONFIGURATION_AIS_BIT];
  assign rx_take = RX_VALID_I & RX_READY_O;
  assign reg_ch  = REG_ADDR_I[CHAN_W-1:0];
  assign mem_we  = REG_WR_I & ((REG_ADDR_I[7:4] == REGION_TXCI) | (REG_ADDR_I[7:4] == REGION_TXMON));
  assign mon_wr  = REG_WR_I & (REG_ADDR_I[7:4] == REGION_TXMON);
  assign mem_a_addr = mem_index(REG_ADDR_I[7:4] == REGION_TXMON, reg_ch);

  // transmit command registers live in the store, one byte each
  gcm_store u_store (
    .clk_i     (CLOCK_I),
    .ce_i      (CE_I),
    .we_i      (mem_we),                                     // RULE14
    .waddr_i   (mem_a_addr),
    .wdata_i   (REG_WDATA_I[MEM_DW-1:0]),
    .ra_addr_i (mem_a_addr),
    .ra_data_o (mem_a_rdata),
    .rb_addr_i (mem_b_addr),
    .rb_data_o (mem_b_rdata)
  );

  // ----------------------------------------------------------------
  // register port: writes, and a two-cycle read path
  // ----------------------------------------------------------------
  // every read answers two edges later so store and flop reads look alike
  always_comb begin
    next_gencfg   = gencfg;
    next_matcfg   = matcfg;
    next_cmem     = cmem;
    next_ci_mode  = ci_mode;
    next_mon_mode = mon_mode;
    next_rd_p1    = REG_RD_I;
    next_rd_mem_q = 1'b0;
    next_rd_hold  = '0;
    next_rdata    = rd_mem_q ? {8'h00, mem_a_rdata} : rd_hold;
    if (REG_WR_I) begin
      if (REG_ADDR_I == ADDR_GENCFG) begin
        next_gencfg = REG_WDATA_I;
      end else if (REG_ADDR_I == ADDR_MATCFG) begin
        next_matcfg = REG_WDATA_I;
      end else if (REG_ADDR_I == ADDR_CMEM) begin
        next_cmem = REG_WDATA_I;
      end else if (REG_ADDR_I[7:4] == REGION_CHCFG) begin
        next_ci_mode[reg_ch]  = REG_WDATA_I[CHCFG_CI_LSB +: 2];   // RULE6
        next_mon_mode[reg_ch] = REG_WDATA_I[CHCFG_MON_LSB +: 2];  // RULE7
      end
    end
    if (REG_RD_I) begin
      if (REG_ADDR_I == ADDR_GENCFG) begin
        next_rd_hold = gencfg;
      end else if (REG_ADDR_I == ADDR_MATCFG) begin
        next_rd_hold = matcfg;
      end else if (REG_ADDR_I == ADDR_CMEM) begin
        next_rd_hold = cmem;
      end else if (REG_ADDR_I[7:4] == REGION_CHCFG) begin
        next_rd_hold[CHCFG_CI_LSB +: 2]  = ci_mode[reg_ch];
        next_rd_hold[CHCFG_MON_LSB +: 2] = mon_mode[reg_ch];
        next_rd_hold[CHCFG_PEND_BIT]     = pend[reg_ch];
      end else if (REG_ADDR_I[7:4] == REGION_TXCI || REG_ADDR_I[7:4] == REGION_TXMON) begin
        next_rd_mem_q = 1'b1;                                     // RULE14
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      gencfg       <= '0;
      matcfg       <= '0;
      cmem         <= '0;
      ci_mode      <= '{default: '0};
      mon_mode     <= '{default: '0};
      rd_p1        <= 1'b0;
      rd_mem_q     <= 1'b0;
      rd_hold      <= '0;
      REG_RACK_O   <= 1'b0;
      REG_RDATA_O  <= '0;
      SHUFFLE_EN_O <= 1'b0;
    end else if (CE_I) begin
      gencfg       <= next_gencfg;
      matcfg       <= next_matcfg;
      cmem         <= next_cmem;
      ci_mode      <= next_ci_mode;
      mon_mode     <= next_mon_mode;
      rd_p1        <= next_rd_p1;
      rd_mem_q     <= next_rd_mem_q;
      rd_hold      <= next_rd_hold;
      REG_RACK_O   <= rd_p1;
      REG_RDATA_O  <= next_rdata;
      SHUFFLE_EN_O <= next_cmem[CONNECTION_MEMORY_DATA_SHUFFLE_BIT];               // RULE15
    end
  end

  // ----------------------------------------------------------------
  // receive side: slot decode and event generation
  // ----------------------------------------------------------------
  logic              push_a, push_b, ack_hit, ais_now;
  logic [CHAN_W-1:0] rx_ch;
  logic [1:0]        rx_pos;
  logic [7:0]        rx_by;
  logic [5:0]        ci_now;
  gcm_evt_t          evt_a, evt_b;
  logic [7:0]        next_rxb;
  logic [1:0]        next_rxd;
  logic [CHAN_W-1:0] next_rxd_ch;
  logic              next_rxb_v, next_rxd_v;

  assign rx_ch  = chan_of(RX_SLOT_I.mux, RX_SLOT_I.slot);        // RULE1 RULE2
  assign rx_pos = RX_SLOT_I.slot[1:0];
  assign rx_by  = RX_SLOT_I.data;

  // at most one primitive and one supervision event per slot, hence two pushes
  always_comb begin
    next_last_ci   = last_ci;
    next_six_last  = six_last;
    next_mon_rx    = mon_rx;
    next_rx_e_last = rx_e_last;
    next_b1_ones   = b1_ones;
    next_ais_state = ais_state;
    next_rxb       = RX_B_O;
    next_rxb_v     = 1'b0;
    next_rxd       = RX_D_O;
    next_rxd_ch    = RX_D_CHAN_O;
    next_rxd_v     = 1'b0;
    push_a = 1'b0;
    push_b = 1'b0;
    evt_a  = '0;
    evt_b  = '0;
    ack_hit = 1'b0;
    ais_now = 1'b0;
    ci_now  = '0;
    if (rx_take) begin
      case (rx_pos)
        POS_B1: begin
          next_rxb   = rx_by;                                     // RULE4
          next_rxb_v = 1'b1;
          next_b1_ones[rx_ch] = (rx_by == BYTE_ONES);
        end
        POS_B2: begin
          next_rxb   = rx_by;                                     // RULE4
          next_rxb_v = 1'b1;
          ais_now    = b1_ones[rx_ch] & (rx_by == BYTE_ONES);
          if (ais_en && ais_now != ais_state[rx_ch]) begin
            next_ais_state[rx_ch] = ais_now;                      // RULE21
            push_a = 1'b1;
            evt_a  = '{kind: EVT_AIS, chan: rx_ch, data: {7'h00, ais_now}};
          end
        end
        POS_MON: begin
          if (six_en) begin
            // slot carries D, A, E and the spare bits of the ISDN side
            next_rxd    = rx_by[SC_D_LSB +: 2];                   // RULE16
            next_rxd_ch = rx_ch;
            next_rxd_v  = 1'b1;
            if (rx_by[5:0] != six_last[rx_ch]) begin
              next_six_last[rx_ch] = rx_by[5:0];                  // RULE20
              push_a = 1'b1;
              evt_a  = '{kind: EVT_SIX, chan: rx_ch, data: {2'b00, rx_by[5:0]}};
            end
          end else begin
            next_mon_rx[rx_ch] = rx_by;                           // RULE3 RULE10
          end
        end
        default: begin
          if (ci_mode[rx_ch] == CI_ISDN) begin
            next_rxd    = rx_by[SC_D_LSB +: 2];                   // RULE5 RULE11
            next_rxd_ch = rx_ch;
            next_rxd_v  = 1'b1;
            ci_now      = {2'b00, rx_by[SC_CI_LSB +: 4]};         // RULE6
          end else if (ci_mode[rx_ch] == CI_ANALOG) begin
            ci_now      = rx_by[SC_CI_LSB +: 6];                  // RULE6
          end
          if (ci_mode[rx_ch] != CI_OFF && ci_now != last_ci[rx_ch]) begin
            next_last_ci[rx_ch] = ci_now;                         // RULE13
            push_a = 1'b1;
            evt_a  = '{kind: EVT_CI, chan: rx_ch, data: {2'b00, ci_now}};
          end
          if (mon_mode[rx_ch] == MON_VSTAR && rx_by[SC_E_BIT]) begin
            push_b = 1'b1;                                        // RULE9 RULE13
            evt_b  = '{kind: EVT_MON, chan: rx_ch, data: mon_rx[rx_ch]};
          end else if (mon_mode[rx_ch] == MON_GCI) begin
            if (rx_by[SC_E_BIT] && !rx_e_last[rx_ch]) begin
              push_b = 1'b1;                                      // RULE8 RULE13
              evt_b  = '{kind: EVT_MON, chan: rx_ch, data: mon_rx[rx_ch]};
            end
            next_rx_e_last[rx_ch] = rx_by[SC_E_BIT];              // RULE8
            ack_hit = rx_by[SC_A_BIT];
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      last_ci      <= '{default: '0};
      six_last     <= '{default: '0};
      mon_rx       <= '{default: '0};
      rx_e_last    <= '0;
      b1_ones      <= '0;
      ais_state    <= '0;
      RX_B_O       <= '0;
      RX_B_VALID_O <= 1'b0;
      RX_D_O       <= '0;
      RX_D_CHAN_O  <= '0;
      RX_D_VALID_O <= 1'b0;
    end else if (CE_I) begin
      last_ci      <= next_last_ci;
      six_last     <= next_six_last;
      mon_rx       <= next_mon_rx;
      rx_e_last    <= next_rx_e_last;
      b1_ones      <= next_b1_ones;
      ais_state    <= next_ais_state;
      RX_B_O       <= next_rxb;
      RX_B_VALID_O <= next_rxb_v;
      RX_D_O       <= next_rxd;
      RX_D_CHAN_O  <= next_rxd_ch;
      RX_D_VALID_O <= next_rxd_v;
    end
  end

  // ----------------------------------------------------------------
  // two-entry event buffer
  // ----------------------------------------------------------------
  // slots are taken only with both entries free, so no event can be dropped
  gcm_evt_t   buf1, next_buf0, next_buf1;
  logic [1:0] count, next_count;
  logic       pop;

  assign pop = EVT_VALID_O & EVT_READY_I;

  always_comb begin
    next_buf0  = EVT_O;
    next_buf1  = buf1;
    next_count = count;
    if (pop) begin
      next_buf0  = buf1;
      next_count = count - 2'd1;
    end
    if (push_a) begin
      if (next_count == 2'd0) next_buf0 = evt_a;
      else next_buf1 = evt_a;
      next_count = next_count + 2'd1;
    end
    if (push_b) begin
      if (next_count == 2'd0) next_buf0 = evt_b;
      else next_buf1 = evt_b;
      next_count = next_count + 2'd1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      EVT_O       <= '0;
      buf1        <= '0;
      count       <= '0;
      EVT_VALID_O <= 1'b0;
      RX_READY_O  <= 1'b0;
    end else if (CE_I) begin
      EVT_O       <= next_buf0;
      buf1        <= next_buf1;
      count       <= next_count;
      EVT_VALID_O <= (next_count != 2'd0);
      RX_READY_O  <= (next_count == 2'd0);                        // RULE13
    end
  end

  // ----------------------------------------------------------------
  // transmit side: rebuild supervision and signalling bytes
  // ----------------------------------------------------------------
  gcm_slot_t         tx_q;
  logic              tx_q_v, vs_done;
  logic [CHAN_W-1:0] tx_ch, req_ch;
  logic [7:0]        tx_byte;

  assign req_ch     = chan_of(TX_SLOT_I.mux, TX_SLOT_I.slot);
  assign mem_b_addr = mem_index(TX_SLOT_I.slot[1:0] == POS_MON && !six_en, req_ch);
  assign tx_ch      = chan_of(tx_q.mux, tx_q.slot);

  always_comb begin
    tx_byte = BYTE_ONES;
    vs_done = 1'b0;
    case (tx_q.slot[1:0])
      POS_B1, POS_B2: tx_byte = tx_q.data;                        // RULE4
      POS_MON: begin
        if (six_en) begin
          tx_byte = {tx_q.dbits, mem_b_rdata[5:0]};               // RULE16 RULE19
        end else if (mon_mode[tx_ch] != MON_OFF && pend[tx_ch]) begin
          tx_byte = mem_b_rdata;                                  // RULE3 RULE12
        end
      end
      default: begin
        if (ci_mode[tx_ch] == CI_ANALOG) begin
          tx_byte[SC_CI_LSB +: 6] = mem_b_rdata[5:0];             // RULE6 RULE12
        end else if (ci_mode[tx_ch] == CI_ISDN) begin
          tx_byte[SC_D_LSB +: 2]  = tx_q.dbits;                   // RULE5 RULE12
          tx_byte[SC_CI_LSB +: 4] = mem_b_rdata[3:0];
        end
        if (mon_mode[tx_ch] == MON_GCI) begin
          tx_byte[SC_A_BIT] = rx_e_last[tx_ch];                   // RULE8 RULE10
          tx_byte[SC_E_BIT] = pend[tx_ch];
        end else if (mon_mode[tx_ch] == MON_VSTAR) begin
          tx_byte[SC_A_BIT] = 1'b1;                               // RULE9
          tx_byte[SC_E_BIT] = pend[tx_ch];
          vs_done = tx_q_v & pend[tx_ch];
        end
      end
    endcase
  end

  // host write sets pending and wins over an acknowledge in the same cycle
  always_comb begin
    next_pend = pend;
    if (ack_hit) next_pend[rx_ch] = 1'b0;                         // RULE8
    if (vs_done) next_pend[tx_ch] = 1'b0;                         // RULE9
    if (mon_wr) next_pend[reg_ch] = 1'b1;                         // RULE14
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      tx_q       <= '0;
      tx_q_v     <= 1'b0;
      pend       <= '0;
      TX_BYTE_O  <= BYTE_ONES;
      TX_VALID_O <= 1'b0;
    end else if (CE_I) begin
      tx_q       <= TX_SLOT_I;
      tx_q_v     <= TX_REQ_I;
      pend       <= next_pend;
      TX_BYTE_O  <= tx_byte;
      TX_VALID_O <= tx_q_v;
    end
  end

endmodule // gcm_handler

// >>> logic/gcm_pkg.sv
// package for the command/indicate and supervision channel handler:
// register map, slot layout, field positions, channel modes, event kinds.
// assumes a byte-wide time-slot stream from the multiplex serialisers on the same clock.
package gcm_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_CHAN = 16;
  localparam int CHAN_W   = 4;
  localparam int SLOT_W   = 5;
  localparam int MEM_AW   = 5;
  localparam int MEM_DW   = 8;

  // ----------------------------------------------------------------
  // register map (word offsets on the register port)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_GENCFG  = 8'h02;  // general_configuration
  localparam logic [7:0] ADDR_MATCFG  = 8'h0C;  // matrix_configuration
  localparam logic [7:0] ADDR_CMEM    = 8'h0E;  // connection_memory_data
  localparam logic [3:0] REGION_CHCFG = 4'h2;   // 0x20..0x2F channel config/status
  localparam logic [3:0] REGION_TXCI  = 4'h4;   // 0x40..0x4F primitive transmit commands
  localparam logic [3:0] REGION_TXMON = 4'h6;   // 0x60..0x6F supervision transmit commands

  // register fields
  localparam int GCR_SIX_BIT      = 0;  // six_bit_word_enable
  localparam int MATRIX_CONFIGURATION_AIS_BIT     = 0;  // alarm_signal_detect_enable
  localparam int CONNECTION_MEMORY_DATA_SHUFFLE_BIT = 0;  // bchan_shuffle_select
  localparam int CHCFG_CI_LSB     = 0;
  localparam int CHCFG_MON_LSB    = 2;
  localparam int CHCFG_PEND_BIT   = 7;

  // ----------------------------------------------------------------
  // slot layout inside a channel and signalling/control byte fields
  // ----------------------------------------------------------------
  localparam logic [1:0] POS_B1  = 2'h0;
  localparam logic [1:0] POS_B2  = 2'h1;
  localparam logic [1:0] POS_MON = 2'h2;
  localparam logic [1:0] POS_SC  = 2'h3;
  localparam int SC_E_BIT   = 0;
  localparam int SC_A_BIT   = 1;
  localparam int SC_CI_LSB  = 2;   // both 4-bit and 6-bit fields start here
  localparam int SC_D_LSB   = 6;   // two D bits of the ISDN layout
  localparam logic [7:0] BYTE_ONES = 8'hFF;

  // channel modes
  localparam logic [1:0] CI_OFF    = 2'h0;
  localparam logic [1:0] CI_ANALOG = 2'h1;
  localparam logic [1:0] CI_ISDN   = 2'h2;
  localparam logic [1:0] MON_OFF   = 2'h0;
  localparam logic [1:0] MON_VSTAR = 2'h1;
  localparam logic [1:0] MON_GCI   = 2'h2;

  // event kinds written to shared memory
  localparam logic [1:0] EVT_CI  = 2'h0;
  localparam logic [1:0] EVT_MON = 2'h1;
  localparam logic [1:0] EVT_SIX = 2'h2;
  localparam logic [1:0] EVT_AIS = 2'h3;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              mux;    // 0: multiplex four, 1: multiplex five
    logic [SLOT_W-1:0] slot;   // time slot 0..31
    logic [7:0]        data;   // slot byte (tx: B byte from the matrix)
    logic [1:0]        dbits;  // tx only: D bits from the HDLC transmitter
  } gcm_slot_t;

  typedef struct packed {
    logic [1:0]        kind;
    logic [CHAN_W-1:0] chan;
    logic [7:0]        data;
  } gcm_evt_t;

endpackage

// >>> logic/gcm_store.sv
// transmit command store: 32 bytes, one write port and two registered read ports.
// assumes the owner gives it the same clock and clock enable; contents are not reset.
`timescale 1ns/10ps
module gcm_store (
  // clock
  input  wire logic                       clk_i,
  input  wire logic                       ce_i,
  // write port
  input  wire logic                       we_i,
  input  wire logic [gcm_pkg::MEM_AW-1:0] waddr_i,
  input  wire logic [gcm_pkg::MEM_DW-1:0] wdata_i,
  // read ports
  input  wire logic [gcm_pkg::MEM_AW-1:0] ra_addr_i,
  output logic      [gcm_pkg::MEM_DW-1:0] ra_data_o,
  input  wire logic [gcm_pkg::MEM_AW-1:0] rb_addr_i,
  output logic      [gcm_pkg::MEM_DW-1:0] rb_data_o
);
  import gcm_pkg::*;

  logic [MEM_DW-1:0] mem [2**MEM_AW];

  // ----------------------------------------------------------------
  // storage, read data always come out of a register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      ra_data_o <= mem[ra_addr_i];
      rb_data_o <= mem[rb_addr_i];
    end
  end

endmodule // gcm_store

// >>> test/gcm_handler_properties.sv
// checker: port timing of the channel handler
// assumes CE_I high; bound to gcm_handler
`timescale 1ns/10ps
module gcm_chk
  import gcm_pkg::*;
(
  // clock, reset, register port
  input wire logic CLOCK_I, RESET_N_I, REG_WR_I, REG_RD_I, REG_RACK_O, SHUFFLE_EN_O,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  // streams and events
  input wire logic RX_VALID_I, RX_READY_O, RX_B_VALID_O, TX_REQ_I, TX_VALID_O, EVT_VALID_O, EVT_READY_I,
  input wire logic [7:0] RX_B_O, TX_BYTE_O,
  input wire gcm_slot_t RX_SLOT_I, TX_SLOT_I,
  input wire gcm_evt_t EVT_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);
  property p_rack; REG_RD_I |-> ##2 REG_RACK_O; endproperty
  a_rack: assert property (p_rack) else $error("read answer late");
  property p_rsrc; REG_RACK_O |-> $past(REG_RD_I, 2); endproperty
  a_rsrc: assert property (p_rsrc) else $error("stray read answer");
  property p_tx; TX_REQ_I |-> ##2 TX_VALID_O; endproperty
  a_tx: assert property (p_tx) else $error("transmit answer late");
  property p_txb; TX_REQ_I && !TX_SLOT_I.slot[1] |-> ##2 TX_BYTE_O == $past(TX_SLOT_I.data, 2); endproperty
  a_txb: assert property (p_txb) else $error("sent data byte altered");
  property p_rxb;
    RX_VALID_I && RX_READY_O && !RX_SLOT_I.slot[1] |=> RX_B_VALID_O && RX_B_O == $past(RX_SLOT_I.data);
  endproperty
  a_rxb: assert property (p_rxb) else $error("received data byte altered");
  property p_ev; EVT_VALID_O && !EVT_READY_I |=> EVT_VALID_O && $stable(EVT_O); endproperty
  a_ev: assert property (p_ev) else $error("event lost in stall");
  property p_rdy; RX_READY_O && !RX_VALID_I |=> !EVT_VALID_O; endproperty
  a_rdy: assert property (p_rdy) else $error("event without slot");
  property p_shf; REG_WR_I && REG_ADDR_I == ADDR_CMEM |-> ##2 SHUFFLE_EN_O == $past(REG_WDATA_I[0], 2); endproperty
  a_shf: assert property (p_shf) else $error("shuffle select wrong");
  c_evt: cover property (EVT_VALID_O && EVT_READY_I);
  c_rd: cover property (REG_RACK_O);
  c_tx: cover property (TX_VALID_O);
endmodule // gcm_chk
bind gcm_handler gcm_chk chk_u (.*);

// >>> test/gcm_handler_tb.sv
// self-checking bench for gcm_handler
// assumes a line model on receive and a consumer that stalls every other cycle
`timescale 1ns/10ps
module gcm_handler_tb;
  import gcm_pkg::*;
  logic clk, rst_n, wrs, rds, treq, erdy, rack, tval, rvalid, rready, evalid;
  logic [7:0] adr, tbyte, c, m, v;
  logic [15:0] wdat, rdata, seed;
  logic [1:0] d;
  logic [5:0] dq;
  logic [7:0] cfg[3] = '{ADDR_GENCFG, ADDR_MATCFG, ADDR_CMEM};
  gcm_slot_t rslot, tslot;
  gcm_evt_t evt, evq[$];
  int fails, checks_done;
  gcm_handler dut_u (.CLOCK_I(clk), .RESET_N_I(rst_n), .CE_I(1'b1), .REG_ADDR_I(adr), .REG_WDATA_I(wdat),
    .REG_WR_I(wrs), .REG_RD_I(rds), .REG_RDATA_O(rdata), .REG_RACK_O(rack), .RX_VALID_I(rvalid),
    .RX_SLOT_I(rslot), .RX_READY_O(rready), .RX_B_O(), .RX_B_VALID_O(), .RX_D_O(dq[1:0]), .RX_D_CHAN_O(dq[5:2]),
    .RX_D_VALID_O(), .TX_REQ_I(treq), .TX_SLOT_I(tslot), .TX_BYTE_O(tbyte), .TX_VALID_O(tval),
    .EVT_VALID_O(evalid), .EVT_O(evt), .EVT_READY_I(erdy), .SHUFFLE_EN_O());
  gcm_line_model line_u (.clk_i(clk), .ready_i(rready), .valid_o(rvalid), .slot_o(rslot));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // consumer stalls every other cycle so events must wait in the buffer
  always @(posedge clk) begin
    erdy <= ~erdy;
    if (evalid && erdy) evq.push_back(evt);
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wn, input logic [7:0] a, input logic [15:0] w);
    @(posedge clk);
    adr <= a; wdat <= w; wrs <= wn; rds <= !wn;
    @(posedge clk);
    wrs <= 1'b0; rds <= 1'b0;
    if (!wn) begin
      @(posedge clk);
      #1 chk(rack ? rdata : ~w, w);
    end
  endtask
  task automatic tx(input logic [4:0] s, input logic [7:0] b, input logic [7:0] e);
    @(posedge clk);
    treq <= 1'b1; tslot <= '{1'b0, s, b, d};
    @(posedge clk);
    treq <= 1'b0;
    @(posedge clk);
    #1 chk({8'h00, tval ? tbyte : ~e}, {8'h00, e});
  endtask
  task automatic complete_run();
    if (fails == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {wrs, rds, treq, erdy, adr, wdat, tslot, d} = '0;
    rst_n = 1'b0;
    seed = 16'h0041;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    foreach (cfg[i]) begin
      seed = lfsr(seed);
      bus(1, cfg[i], seed);
      bus(0, cfg[i], seed);
      bus(1, cfg[i], 16'h0000);
    end
    bus(0, 8'h7F, 16'h0000);
    seed = lfsr(seed);
    {m, c} = seed;
    d = seed[9:8];
    bus(1, 8'h45, {8'hA5, c});
    bus(1, 8'h65, {8'h00, m});
    bus(0, 8'h45, {8'h00, c});
    bus(1, 8'h25, 16'h000A);
    bus(0, 8'h25, 16'h008A);
    tx(5'd22, c, m);
    tx(5'd23, c, {d, c[3:0], 2'b01});
    repeat (8) begin
      seed = lfsr(seed);
      tx({seed[4:2], 1'b0, seed[5]}, seed[15:8], seed[15:8]);
      line_u.send(seed[6], {seed[4:2], 1'b0, seed[5]}, seed[15:8]);
    end
    v = seed[7:0];
    line_u.send(1'b0, 5'd22, v);
    line_u.send(1'b0, 5'd23, 8'hCF);
    repeat (80) if (evq.size() < 2) @(posedge clk);
    chk(16'({evq[0].kind, evq[0].chan, dq}), 16'({EVT_CI, 4'h5, 4'h5, 2'b11}));
    chk(16'({evq[1].kind, evq[1].chan, evq[1].data}), 16'({EVT_MON, 4'h5, v}));
    bus(0, 8'h25, 16'h000A);
    tx(5'd23, c, {d, c[3:0], 2'b10});
    bus(1, 8'h66, {8'h00, v});
    bus(1, 8'h26, 16'h0004);
    tx(5'd26, v, v);
    tx(5'd27, v, 8'hFF);
    tx(5'd27, v, 8'hFE);
    bus(1, cfg[0], 16'h0001);
    bus(1, cfg[1], 16'h0001);
    tx(5'd22, c, {d, c[5:0]});
    line_u.send(1'b0, 5'd20, 8'hFF);
    line_u.send(1'b0, 5'd21, 8'hFF);
    line_u.send(1'b0, 5'd22, 8'h96);
    repeat (80) if (evq.size() < 4) @(posedge clk);
    chk(16'({evq[2].kind, evq[2].data}), 16'({EVT_AIS, 8'h01}));
    chk({evq[3].kind, evq[3].data, dq}, {EVT_SIX, 8'h16, 4'h5, 2'b10});
    complete_run();
  end
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    complete_run();
  end
endmodule // gcm_handler_tb

// >>> test/gcm_line_model.sv
// line transceiver side: offers receive slot bytes in order
// assumes the bench queues slots through send()
`timescale 1ns/10ps
module gcm_line_model
  import gcm_pkg::*;
(
  // clock and handshake
  input wire logic clk_i,
  input wire logic ready_i,
  output logic valid_o,
  output gcm_slot_t slot_o
);
  gcm_slot_t q[$];
  initial valid_o = 1'b0;
  initial slot_o = '0;
  task automatic send(input logic mx, input logic [4:0] s, input logic [7:0] dt);
    q.push_back('{mx, s, dt, 2'h0});
  endtask
  // hold each slot until taken; idle line toggles so a stale byte never looks valid
  always @(posedge clk_i) begin
    if (valid_o && ready_i) void'(q.pop_front());
    valid_o <= q.size() != 0;
    slot_o <= (q.size() != 0) ? q[0] : ~slot_o;
  end
endmodule // gcm_line_model
